// File: inc/asmd_pkg.sv
`default_nettype none
package asmd_pkg;
  // clock and derived timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_CYC = CLK_HZ / BAUD_RATE;
  localparam int POLL_MS = 100;
  localparam int POLL_CYC = CLK_HZ / 1000 * POLL_MS;
  localparam int DLY_UNIT_MS = 10;
  localparam int DLY_UNIT_CYC = CLK_HZ / 1000 * DLY_UNIT_MS;
  // buffer sizes
  localparam int IBUF_BYTES = 1024;
  localparam int MAX_FRAMES = 100;
  localparam int MBOX_BYTES = 64;
  // register word addresses
  localparam logic [11:0] A_PSEL = 12'h000;
  localparam logic [11:0] A_SCB = 12'h001;
  localparam logic [11:0] A_RCB = 12'h002;
  localparam logic [11:0] A_MODE = 12'h003;
  localparam logic [11:0] A_END = 12'h004;
  localparam logic [11:0] A_LEN = 12'h005;
  localparam logic [11:0] A_DLY = 12'h006;
  localparam logic [11:0] A_CFG = 12'h007;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [3:0] A_SMB_PAGE = 4'h1;
  localparam logic [3:0] A_RMB_PAGE = 4'h2;
  // reset values
  localparam logic [7:0] PSEL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [15:0] END_RST = 16'h0d0a;
  localparam logic [15:0] LEN_RST = 16'h0040;
  localparam logic [15:0] DLY_RST = 16'h000a;
  localparam logic [7:0] CFG_RST = 8'h0f;
  // config bit positions
  localparam int CFG_SMB = 0;
  localparam int CFG_RMB = 1;
  localparam int CFG_SCB = 2;
  localparam int CFG_RCB = 3;
  localparam int CFG_PAR = 4;
  localparam int CB_PERM = 7;
  // port selection codes
  localparam logic [7:0] PSEL_ASCII = 8'h01;
  localparam logic [7:0] PE_NO_DRV = 8'h01;
  localparam logic [7:0] PE_NO_SCB = 8'h10;
  localparam logic [7:0] PE_NO_RCB = 8'h20;
  localparam logic [7:0] PE_NO_BOTH = 8'h40;
  // coordination byte codes
  localparam logic [6:0] SE_OBUF_FULL = 7'h07;
  localparam logic [6:0] SE_PARAM = 7'h0d;
  localparam logic [6:0] SE_NO_SMB = 7'h11;
  localparam logic [6:0] SE_TOO_LONG = 7'h13;
  localparam logic [6:0] RE_DELAY = 7'h01;
  localparam logic [6:0] RE_PARITY = 7'h03;
  localparam logic [6:0] RE_AFTER_XOFF = 7'h05;
  localparam logic [6:0] RE_BUF_FULL = 7'h07;
  localparam logic [6:0] RE_FRAMES = 7'h09;
  localparam logic [6:0] RE_TOO_BIG = 7'h0b;
  localparam logic [6:0] RE_NO_RMB = 7'h0f;
  localparam logic [6:0] RE_BREAK = 7'h1b;
  // control characters
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_RUBOUT = 8'h7f;
  typedef enum logic [1:0] {TF_IDLE, TF_RUN, TF_DRAIN} asmd_tx_e;
endpackage : asmd_pkg
`default_nettype wire

// File: logic/asmd_driver.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - driver runs only while port selection high byte is 01h
// - setup failures show in selection low byte: 01h, 10h, 20h, 40h
// - panel and programmer functions are off while driver is active
// - received frames move into the receive mailbox only every 100 ms
// - receive input buffer holds 1024 bytes in every mode
// - after XOFF, keep receiving until buffer or frame count is full
// - rising send-permitted bit starts sending; device clears it when done
// - user sets receive-permitted; device clears it when mailbox fills
// - coordination bits may change on any cycle
// - send errors 07h, 0Dh, 11h, 13h go into send coordination byte
// - receive codes 01h, 03h, 05h, 07h go into receive coordination byte
// - receive codes 09h, 0Bh, 0Fh, 1Bh with their reactions
// - up to 100 frames are held while receive byte is zero
// - modes 1-3 use no control characters, modes 4-8 use XON/XOFF
// - interpreting modes send XOFF on permit fall, XON on permit rise
// - mode 1 sends counted bytes, receives fixed length, default 64
// - mode 2 frames end with low end character, which is sent
// - mode 3 frames end with high then low end character, both sent
// - modes 4,5 add RUB OUT delete and XON/XOFF send flow control
// - mode 6 sends up to low end character without sending it
// - mode 7 omits count word; modes 6,7 receive only XON and XOFF
// - mode 8 is mode 1 with interpretation; timeout gives 01h
// - parameters latch only while both permit bits are zero
module asmd_driver
  import asmd_pkg::*;
#(
  parameter int BAUD_DIV = BAUD_CYC,
  parameter int POLL_DIV = POLL_CYC,
  parameter int DLY_DIV = DLY_UNIT_CYC,
  parameter int IBUF_DEPTH = IBUF_BYTES,
  parameter int SMB_BYTES = MBOX_BYTES,
  parameter int RMB_BYTES = MBOX_BYTES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rxd,
  output logic txd,
  output logic panel_en
);
  localparam int IW = $clog2(IBUF_DEPTH);
  localparam int CW = IW + 1;
  localparam int SW = $clog2(SMB_BYTES);
  localparam int RW = $clog2(RMB_BYTES);

  logic [7:0] psel_reg, scb_reg, rcb_reg, mode_reg, cfg_reg, pe_code;
  logic [15:0] end_reg, len_reg, dly_reg, act_end, act_len, act_dly;
  logic [7:0] act_mode, smb_mem [SMB_BYTES], rmb_mem [RMB_BYTES];
  logic [8:0] ib_mem [IBUF_DEPTH];
  logic active, m_cnt, m_one, m_interp, m_rub, m_prn, mode_bad;
  logic wr_scb, wr_rcb, scb_q, rcb_q, send_rise;
  // register file writes
  logic [11:0] a_hi;
  assign a_hi = reg_addr;
  assign wr_scb = reg_wr && a_hi == A_SCB;
  assign wr_rcb = reg_wr && a_hi == A_RCB;

  // driver selection and setup check
  assign active = psel_reg == PSEL_ASCII;
  assign panel_en = !active;
  always_comb begin
    pe_code = 8'h00;
    if (psel_reg != PSEL_RST && !active)
      pe_code = PE_NO_DRV;
    else if (active && !cfg_reg[CFG_SCB] && !cfg_reg[CFG_RCB])
      pe_code = PE_NO_BOTH;
    else if (active && !cfg_reg[CFG_SCB])
      pe_code = PE_NO_SCB;
    else if (active && !cfg_reg[CFG_RCB])
      pe_code = PE_NO_RCB;
  end

  // mode decode from the latched mode number
  assign m_cnt = act_mode == 8'h01 || act_mode == 8'h07 || act_mode == 8'h08;
  assign m_one = act_mode == 8'h02 || act_mode == 8'h04;
  assign m_interp = act_mode >= 8'h04 && act_mode <= 8'h08;
  assign m_rub = act_mode == 8'h04 || act_mode == 8'h05 || act_mode == 8'h08;
  assign m_prn = act_mode == 8'h06 || act_mode == 8'h07;
  assign mode_bad = act_mode == 8'h00 || act_mode > 8'h08;

  // plain configuration registers and send mailbox
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      psel_reg <= PSEL_RST;
      mode_reg <= MODE_RST;
      end_reg <= END_RST;
      len_reg <= LEN_RST;
      dly_reg <= DLY_RST;
      cfg_reg <= CFG_RST;
    end else if (reg_wr) begin
      if (a_hi == A_PSEL) psel_reg <= reg_wdata[15:8];
      if (a_hi == A_MODE) mode_reg <= reg_wdata[7:0];
      if (a_hi == A_END) end_reg <= reg_wdata;
      if (a_hi == A_LEN) len_reg <= reg_wdata;
      if (a_hi == A_DLY) dly_reg <= reg_wdata;
      if (a_hi == A_CFG) cfg_reg <= reg_wdata[7:0];
    end
  end
  // mailbox contents carry no reset; software fills the send mailbox before use
  always_ff @(posedge mclk) begin
    if (reg_wr && a_hi[11:8] == A_SMB_PAGE)
      smb_mem[a_hi[SW-1:0]] <= reg_wdata[7:0];
  end

  // parameters only change while both permit bits are zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act_mode <= MODE_RST;
      act_end <= END_RST;
      act_len <= LEN_RST;
      act_dly <= DLY_RST;
    end else if (!scb_reg[CB_PERM] && !rcb_reg[CB_PERM]) begin
      act_mode <= mode_reg;
      act_end <= end_reg;
      act_len <= len_reg;
      act_dly <= dly_reg;
    end
  end

  // serial transmitter, one bit per baud period
  logic [10:0] tx_sh;
  logic [3:0] tx_left;
  logic [15:0] tx_cnt;
  logic tx_load, tx_busy, eng_free;
  logic [7:0] tx_byte;
  assign tx_busy = tx_left != 4'h0 || tx_cnt != 16'h0;
  assign eng_free = !tx_busy && !tx_load;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_cnt <= 16'h0;
      txd <= 1'b1;
    end else if (tx_load) begin
      tx_sh <= {1'b1, cfg_reg[CFG_PAR] ? ^tx_byte : 1'b1, tx_byte, 1'b0};
      tx_left <= cfg_reg[CFG_PAR] ? 4'd11 : 4'd10;
    end else if (tx_cnt != 16'h0) begin
      tx_cnt <= tx_cnt - 16'h1;
    end else if (tx_left != 4'h0) begin
      txd <= tx_sh[0];
      tx_sh <= {1'b1, tx_sh[10:1]};
      tx_left <= tx_left - 4'h1;
      tx_cnt <= 16'(BAUD_DIV - 1);
    end
  end

  // send frame sequencer and flow-control characters
  asmd_tx_e tf_st;
  logic [15:0] tf_idx, tf_stop, sm_n;
  logic [7:0] tf_prev, tf_ch, ctrl_ch;
  logic ctrl_pend, xoff_sent, tx_fin, tx_code_v, paused, tf_last;
  logic [6:0] tx_code;
  assign sm_n = {smb_mem[0], smb_mem[1]};
  assign tf_ch = smb_mem[tf_idx[SW-1:0]];
  assign send_rise = scb_reg[CB_PERM] && !scb_q;
  always_comb begin
    if (m_cnt) tf_last = tf_idx + 16'h1 == tf_stop;
    else if (m_one) tf_last = tf_ch == act_end[7:0];
    else tf_last = tf_prev == act_end[15:8] && tf_ch == act_end[7:0];
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tf_st <= TF_IDLE;
      tf_idx <= 16'h0;
      tf_stop <= 16'h0;
      tf_prev <= 8'h00;
      ctrl_pend <= 1'b0;
      ctrl_ch <= 8'h00;
      xoff_sent <= 1'b0;
      tx_load <= 1'b0;
      tx_byte <= 8'h00;
      tx_fin <= 1'b0;
      tx_code_v <= 1'b0;
      tx_code <= 7'h00;
      scb_q <= 1'b0;
      rcb_q <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      tx_fin <= 1'b0;
      tx_code_v <= 1'b0;
      scb_q <= scb_reg[CB_PERM];
      rcb_q <= rcb_reg[CB_PERM];
      // pending drops as it loads, so a data load cannot swallow a new one
      if (eng_free && ctrl_pend) begin
        ctrl_pend <= 1'b0;
        tx_load <= 1'b1;
        tx_byte <= ctrl_ch;
        xoff_sent <= ctrl_ch == CH_XOFF;
      end
      // a late permit edge replaces a control character not yet sent
      if (active && m_interp && rcb_reg[CB_PERM] != rcb_q) begin
        ctrl_pend <= 1'b1;
        ctrl_ch <= rcb_reg[CB_PERM] ? CH_XON : CH_XOFF;
      end
      unique case (tf_st)
        TF_IDLE: if (send_rise && active) begin
          tx_fin <= 1'b1;
          tx_code_v <= 1'b1;
          if (!cfg_reg[CFG_SMB]) tx_code <= SE_NO_SMB;
          else if (mode_bad) tx_code <= SE_PARAM;
          else if (m_cnt && {1'b0, sm_n} + 17'h2 > 17'(SMB_BYTES))
            tx_code <= SE_TOO_LONG;
          else begin
            tx_fin <= 1'b0;
            tx_code_v <= 1'b0;
            tf_idx <= act_mode == 8'h07 ? 16'h2 : 16'h0;
            tf_stop <= sm_n + 16'h2;
            tf_prev <= 8'h00;
            tf_st <= TF_RUN;
          end
        end
        TF_RUN: begin
          if (send_rise) begin
            tx_code_v <= 1'b1;
            tx_code <= SE_OBUF_FULL;
          end
          if (eng_free && !ctrl_pend && !paused) begin
            if (tf_idx == 16'(SMB_BYTES)) begin
              tx_code_v <= 1'b1;
              tx_code <= SE_TOO_LONG;
              tx_fin <= 1'b1;
              tf_st <= TF_IDLE;
            end else if (act_mode == 8'h06 && tf_ch == act_end[7:0]) begin
              tf_st <= TF_DRAIN;
            end else begin
              tx_load <= 1'b1;
              tx_byte <= tf_ch;
              tf_idx <= tf_idx + 16'h1;
              tf_prev <= tf_ch;
              if (tf_last) tf_st <= TF_DRAIN;
            end
          end
        end
        TF_DRAIN: if (eng_free) begin
          tx_fin <= 1'b1;
          tf_st <= TF_IDLE;
        end
      endcase
    end
  end

  // serial receiver, samples each bit near its middle
  logic [10:0] rx_sh;
  logic [3:0] rx_bit;
  logic [15:0] rx_cnt;
  logic rx_busy, rx_done;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_sh <= 11'h000;
      rx_bit <= 4'h0;
      rx_cnt <= 16'h0;
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rxd) begin
          rx_busy <= 1'b1;
          rx_bit <= 4'h0;
          rx_cnt <= 16'(BAUD_DIV / 2 - 1); // detect edge counts as one
        end
      end else if (rx_cnt != 16'h0) begin
        rx_cnt <= rx_cnt - 16'h1;
      end else begin
        rx_sh[rx_bit] <= rxd;
        rx_bit <= rx_bit + 4'h1;
        rx_cnt <= 16'(BAUD_DIV - 1);
        if (rx_bit == (cfg_reg[CFG_PAR] ? 4'd10 : 4'd9)) begin
          rx_busy <= 1'b0;
          rx_done <= 1'b1;
        end
      end
    end
  end

  // received character classification
  logic [7:0] rx_ch, frames, prev_ch;
  logic rx_stop, rx_perr, rx_brk, rx_ok, rx_flow, rx_data, push, del;
  logic eof_new, to_fire, pop_eof, xf_busy, xf_long, xf_ok, tick10, poll;
  logic [IW-1:0] ib_wr, ib_rd, fs_ptr;
  logic [CW-1:0] ib_cnt;
  logic [15:0] frm_len, dly_cnt;
  assign rx_ch = rx_sh[8:1];
  assign rx_stop = cfg_reg[CFG_PAR] ? rx_sh[10] : rx_sh[9];
  assign rx_perr = cfg_reg[CFG_PAR] && (^rx_sh[9:1]);
  assign rx_brk = rx_ch == 8'h00 && !rx_stop;
  assign rx_ok = rx_done && active && !rx_brk && !rx_perr;
  assign rx_flow = rx_ok && m_interp &&
    (rx_ch == CH_XON || rx_ch == CH_XOFF);
  assign rx_data = rx_ok && !rx_flow && !m_prn && !(m_rub && rx_ch == CH_RUBOUT);
  assign del = rx_ok && m_rub && rx_ch == CH_RUBOUT && ib_wr != fs_ptr;
  assign push = rx_data && frames != 8'(MAX_FRAMES) &&
    ib_cnt != CW'(IBUF_DEPTH);
  assign eof_new = m_cnt ? frm_len + 16'h1 == act_len :
    m_one ? rx_ch == act_end[7:0] :
    prev_ch == act_end[15:8] && rx_ch == act_end[7:0];
  assign to_fire = tick10 && !rx_done && frm_len != 16'h0 &&
    dly_cnt + 16'h1 >= act_dly;
  assign pop_eof = xf_busy && ib_mem[ib_rd][8];

  // timebase dividers: 10 ms delay units and the 100 ms poll
  logic [31:0] dly_div, poll_div;
  assign tick10 = dly_div == 32'(DLY_DIV - 1);
  assign poll = poll_div == 32'(POLL_DIV - 1);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dly_div <= 32'h0;
      poll_div <= 32'h0;
    end else begin
      dly_div <= tick10 ? 32'h0 : dly_div + 32'h1;
      poll_div <= poll ? 32'h0 : poll_div + 32'h1;
    end
  end

  // input buffer, frame bookkeeping and mailbox transfer
  logic [RW:0] xf_idx;
  logic rx_code_v;
  logic [6:0] rx_code;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ib_wr <= '0;
      ib_rd <= '0;
      fs_ptr <= '0;
      ib_cnt <= '0;
      frames <= 8'h00;
      frm_len <= 16'h0;
      dly_cnt <= 16'h0;
      prev_ch <= 8'h00;
      paused <= 1'b0;
      rx_code_v <= 1'b0;
      rx_code <= 7'h00;
      xf_busy <= 1'b0;
      xf_long <= 1'b0;
      xf_ok <= 1'b0;
      xf_idx <= '0;
    end else begin
      rx_code_v <= 1'b0;
      xf_ok <= 1'b0;
      ib_cnt <= ib_cnt + CW'(push) - CW'(del) - CW'(xf_busy);
      frames <= frames + 8'(push && eof_new) + 8'(to_fire) - 8'(pop_eof);
      if (!m_interp) paused <= 1'b0;
      else if (rx_flow) paused <= rx_ch == CH_XOFF;
      if (push) begin
        ib_mem[ib_wr] <= {eof_new, rx_ch};
        ib_wr <= ib_wr + 1'b1;
        prev_ch <= rx_ch;
        frm_len <= eof_new ? 16'h0 : frm_len + 16'h1;
        if (eof_new) fs_ptr <= ib_wr + 1'b1;
      end else if (del) begin
        ib_wr <= ib_wr - 1'b1;
        frm_len <= frm_len - 16'h1;
      end
      // a silent line closes the partial frame; its data stay valid
      if (rx_done) dly_cnt <= 16'h0;
      else if (to_fire) begin
        dly_cnt <= 16'h0;
        frm_len <= 16'h0;
        fs_ptr <= ib_wr;
        ib_mem[ib_wr - 1'b1][8] <= 1'b1;
      end else if (tick10 && frm_len != 16'h0) dly_cnt <= dly_cnt + 16'h1;
      // receive status, most serious first
      if (rx_done && active) begin
        rx_code_v <= 1'b1;
        if (rx_brk) rx_code <= RE_BREAK;
        else if (rx_perr) rx_code <= RE_PARITY;
        else if (rx_data && frames == 8'(MAX_FRAMES))
          rx_code <= RE_FRAMES;
        else if (rx_data && !push) rx_code <= RE_BUF_FULL;
        else if (push && xoff_sent) rx_code <= RE_AFTER_XOFF;
        else rx_code_v <= 1'b0;
      end else if (to_fire) begin
        rx_code_v <= 1'b1;
        rx_code <= RE_DELAY;
      end
      // a whole frame moves per poll; software owns the mailbox after
      if (xf_busy) begin
        ib_rd <= ib_rd + 1'b1;
        xf_idx <= xf_idx + 1'b1;
        if (xf_idx < (RW+1)'(RMB_BYTES))
          rmb_mem[xf_idx[RW-1:0]] <= ib_mem[ib_rd][7:0];
        else xf_long <= 1'b1;
        if (pop_eof) begin
          xf_busy <= 1'b0;
          if (xf_long || xf_idx >= (RW+1)'(RMB_BYTES)) begin
            rx_code_v <= 1'b1;
            rx_code <= RE_TOO_BIG;
          end else xf_ok <= 1'b1;
        end
      end else if (poll && active && rcb_reg[CB_PERM] &&
                   frames != 8'h00) begin
        if (!cfg_reg[CFG_RMB]) begin
          rx_code_v <= 1'b1;
          rx_code <= RE_NO_RMB;
        end else begin
          xf_busy <= 1'b1;
          xf_long <= 1'b0;
          xf_idx <= '0;
        end
      end
    end
  end

  // coordination bytes: hardware codes beat a software write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scb_reg <= 8'h00;
      rcb_reg <= 8'h00;
    end else begin
      if (wr_scb) scb_reg <= reg_wdata[7:0];
      else if (tx_fin) scb_reg[CB_PERM] <= 1'b0;
      if (tx_code_v && cfg_reg[CFG_SCB]) scb_reg[6:0] <= tx_code;
      if (wr_rcb) rcb_reg <= reg_wdata[7:0];
      else if (xf_ok) rcb_reg[CB_PERM] <= 1'b0;
      if (rx_code_v && cfg_reg[CFG_RCB]) rcb_reg[6:0] <= rx_code;
    end
  end

  // read data one cycle after the strobe; unmapped words read zero
  always_ff @(posedge mclk) begin
    if (!rst_n) reg_rdata <= 16'h0;
    else if (reg_rd) begin
      reg_rdata <= 16'h0;
      if (a_hi == A_PSEL) reg_rdata <= {psel_reg, pe_code};
      if (a_hi == A_SCB) reg_rdata <= {8'h00, scb_reg};
      if (a_hi == A_RCB) reg_rdata <= {8'h00, rcb_reg};
      if (a_hi == A_MODE) reg_rdata <= {8'h00, mode_reg};
      if (a_hi == A_END) reg_rdata <= end_reg;
      if (a_hi == A_LEN) reg_rdata <= len_reg;
      if (a_hi == A_DLY) reg_rdata <= dly_reg;
      if (a_hi == A_CFG) reg_rdata <= {8'h00, cfg_reg};
      if (a_hi == A_STAT)
        reg_rdata <= {5'h00, tf_st != TF_IDLE, paused, xf_busy, frames};
      if (a_hi[11:8] == A_SMB_PAGE)
        reg_rdata <= {8'h00, smb_mem[a_hi[SW-1:0]]};
      if (a_hi[11:8] == A_RMB_PAGE)
        reg_rdata <= {8'h00, rmb_mem[a_hi[RW-1:0]]};
    end
  end

  sel_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && a_hi == A_PSEL && reg_wdata[15:8] == PSEL_ASCII
    |=> !panel_en) else $error("panel still on with driver");
  both_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
    active && cfg_reg[3:2] == 2'b00 |-> pe_code == PE_NO_BOTH)
    else $error("wrong setup code");
  poll_only_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(xf_busy) |-> $past(poll)) else $error("transfer off poll");
  ibuf_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ib_cnt <= CW'(IBUF_DEPTH)) else $error("input buffer overrun");
  frame_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    frames <= 8'(MAX_FRAMES)) else $error("frame count overrun");
  send_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tx_fin && !wr_scb |=> !scb_reg[CB_PERM])
    else $error("send permit not cleared");
  recv_full_a: assert property (@(posedge mclk) disable iff (!rst_n)
    xf_ok && !wr_rcb |=> !rcb_reg[CB_PERM])
    else $error("receive permit not cleared");
  xoff_on_fall_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(rcb_reg[CB_PERM]) && active && m_interp
    |=> ctrl_pend && ctrl_ch == CH_XOFF) else $error("no XOFF queued");
  no_ctrl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(ctrl_pend) |-> m_interp) else $error("control in plain mode");
  param_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    act_mode != $past(act_mode) |-> $past(!scb_reg[7] && !rcb_reg[7]))
    else $error("mode changed during traffic");
endmodule : asmd_driver
`default_nettype wire

// File: dv/asmd_serial_dev.sv
`timescale 1ns/1ps
`default_nettype none
// far-side ascii device: decodes txd into got, sends characters on rxd
module asmd_serial_dev #(
  parameter int BIT_CYC = 4
) (
  input wire logic mclk,
  input wire logic txd,
  output var logic rxd
);
  logic [7:0] got [$];
  logic [7:0] sh;
  initial rxd = 1'b1;
  // 8n1 decoder; samples near mid-bit, so a one-cycle start jitter is safe
  always begin
    @(posedge mclk);
    if (txd === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        sh[i] = txd;
      end
      repeat (BIT_CYC) @(posedge mclk);
      got.push_back(sh);
    end
  end
  // one character, lsb first; the line rests high after the stop bit
  task send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask : send_byte
endmodule : asmd_serial_dev
`default_nettype wire

// File: dv/ascii_serial_mailbox_driver_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ascii_serial_mailbox_driver_tb
  import asmd_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic rxd;
  logic txd;
  logic panel_en;
  logic [15:0] v;
  int n_mismatch = 0;
  int cmp_count = 0;
  // 10 mhz clock
  always #50 mclk = ~mclk;
  // short counts keep the run to a few thousand cycles
  asmd_driver #(.BAUD_DIV(4), .POLL_DIV(50), .DLY_DIV(10)) dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .panel_en(panel_en));
  // the model's default bit period matches the baud divider above
  asmd_serial_dev dev (.mclk(mclk), .txd(txd), .rxd(rxd));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // data appear in the cycle after the strobe and hold until the next read; sample just then
  task rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // polls a coordination byte until the device drops the permit bit
  task wait_clr(input logic [11:0] a);
    for (int i = 0; i < 400; i++) begin
      rd(a, v);
      if (v[CB_PERM] === 1'b0) break;
    end
  endtask : wait_clr
  task wait_rx(input int n);
    for (int i = 0; i < 300; i++) begin
      if (dev.got.size() >= n) break;
      @(posedge mclk);
    end
  endtask : wait_rx
  task end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task t_reset;
    rd(A_PSEL, v);
    chk(v, 16'h0000);
    chk({15'h0000, panel_en}, 16'h0001);
    rd(A_END, v);
    chk(v, 16'h0d0a);
    rd(A_LEN, v);
    chk(v, 16'h0040);
    rd(12'hfff, v);
    chk(v, 16'h0000);
  endtask : t_reset
  task t_select;
    wr(A_PSEL, 16'h0200);
    rd(A_PSEL, v);
    chk(v, 16'h0201);
    wr(A_PSEL, 16'h0100);
    rd(A_PSEL, v);
    chk(v, 16'h0100);
    chk({15'h0000, panel_en}, 16'h0000);
    wr(A_CFG, 16'h0004);
    rd(A_PSEL, v);
    chk(v, 16'h0120);
    wr(A_CFG, 16'h0003);
    rd(A_PSEL, v);
    chk(v, 16'h0140);
    wr(A_CFG, 16'h000f);
  endtask : t_select
  // count word 0002 then two payload bytes, started by a permit rise
  task load_send(input logic [7:0] mode);
    wr(A_MODE, {8'h00, mode});
    wr(12'h100, 16'h0000);
    wr(12'h101, 16'h0002);
    wr(12'h102, 16'h00a5);
    wr(12'h103, 16'h003c);
    dev.got.delete();
    wr(A_SCB, 16'h0080);
    wait_clr(A_SCB);
    chk(v, 16'h0000);
  endtask : load_send
  task t_send_m1;
    load_send(8'h01);
    chk(16'(dev.got.size()), 16'h0004);
    chk({8'h00, dev.got[1]}, 16'h0002);
    chk({8'h00, dev.got[3]}, 16'h003c);
  endtask : t_send_m1
  task t_send_m7;
    load_send(8'h07);
    chk(16'(dev.got.size()), 16'h0002);
    chk({dev.got[0], dev.got[1]}, 16'ha53c);
  endtask : t_send_m7
  task t_bad_mode;
    wr(A_MODE, 16'h0000);
    wr(A_SCB, 16'h0080);
    wait_clr(A_SCB);
    chk(v, {9'h000, SE_PARAM});
    wr(A_MODE, 16'h0001);
    wr(12'h101, 16'h0040);
    wr(A_SCB, 16'h0080);
    wait_clr(A_SCB);
    chk(v, {9'h000, SE_TOO_LONG});
    wr(A_CFG, 16'h000e);
    wr(A_SCB, 16'h0080);
    wait_clr(A_SCB);
    chk(v, {9'h000, SE_NO_SMB});
    wr(A_CFG, 16'h000f);
  endtask : t_bad_mode
  // a frame closed by the low end character lands at the next poll
  task t_recv_m2;
    wr(A_MODE, 16'h0002);
    dev.got.delete();
    wr(A_RCB, 16'h0080);
    dev.send_byte(8'h41);
    dev.send_byte(8'h0a);
    wait_clr(A_RCB);
    chk(v, 16'h0000);
    rd(12'h200, v);
    chk(v, 16'h0041);
    rd(12'h201, v);
    chk(v, 16'h000a);
    chk(16'(dev.got.size()), 16'h0000);
  endtask : t_recv_m2
  task t_flow_m4;
    wr(A_MODE, 16'h0004);
    dev.got.delete();
    wr(A_RCB, 16'h0080);
    wait_rx(1);
    wr(A_RCB, 16'h0000);
    wait_rx(2);
    chk({dev.got[0], dev.got[1]}, {CH_XON, CH_XOFF});
  endtask : t_flow_m4
  // printer mode stops at the low end character and keeps it back
  task t_send_m6;
    wr(A_END, 16'h0d04);
    wr(12'h104, 16'h0004);
    load_send(8'h06);
    chk(16'(dev.got.size()), 16'h0004);
    chk({dev.got[2], dev.got[3]}, 16'ha53c);
  endtask : t_send_m6
  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_select();
    t_send_m1();
    t_send_m7();
    t_bad_mode();
    t_recv_m2();
    t_flow_m4();
    t_send_m6();
    end_of_test();
  end
endmodule : ascii_serial_mailbox_driver_tb
`default_nettype wire
